// *** hw/sqp_config_port.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Serial configuration port with output squelch and disable
// ****************************************************************
// Notes on behaviour
// - Each port has an 8-bit control: upper nibble squelch, lower disable
// - Both control registers read 0xFF after reset, all outputs enabled
// - Disable nibble zero disables; squelch zero with disable ones squelches
// - Disable powers the transmitter down; wake takes about one microsecond
// - Squelch cuts only output current and recovers much faster
// - Config register bit 4 switches the transmitter fully on or off
// - Registers reached only over the two-wire port, device is slave
// - Works at standard and fast bus clock rates
// - SDA changes only with SCL low, except start and stop
// - Slave address MSB first: fixed 10010b plus two select pins
// - Device acknowledges matching address, register address and data
// - One data byte follows, MSB first, stored into addressed register
// - Repeated start with read bit returns the register just addressed
// - Register pointer kept until reset or a new address phase
// - After read acknowledge the device shifts out the addressed byte
// - Only the master drives SCL; device drives SDA for ack and read
module sqp_config_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  output logic [sqp_pkg::SQP_NPORT-1:0] tx_power_on,
  output logic [sqp_pkg::SQP_NPORT-1:0] tx_drive_on,
  output logic [sqp_pkg::SQP_NPORT-1:0] output_termination_supply_pull
);
  import sqp_pkg::*;

  // ****************************************************************
  // Register index decode
  // ****************************************************************

  // Returns {hit, index}; index order qa, ca, qb, cb
  function automatic logic [2:0] reg_index(input logic [7:0] ofs);
    logic [2:0] r;
    r = 3'h0;
    if (ofs == SQP_OFS_QUIET_A)
      r = 3'h4;
    else if (ofs == SQP_OFS_CFG_A)
      r = 3'h5;
    else if (ofs == SQP_OFS_QUIET_B)
      r = 3'h6;
    else if (ofs == SQP_OFS_CFG_B)
      r = 3'h7;
    else
      r = 3'h0;
    return r;
  endfunction : reg_index

  // ****************************************************************
  // Start and stop detection on the data line
  // ****************************************************************

  logic start_seen;
  logic stop_seen;
  logic start_taken;
  logic start_clr;
  logic stop_clr;

  // Cleared as soon as the engine has taken the start
  assign start_clr = rst | start_taken;
  assign stop_clr = rst | start_seen;

  // SDA falling with SCL high: start or repeated start
  always_ff @(negedge sda_in or posedge start_clr)
  begin
    if (start_clr)
      start_seen <= 1'b0;
    else if (scl_clk)
      start_seen <= 1'b1;
  end

  // SDA rising with SCL high: stop
  always_ff @(posedge sda_in or posedge stop_clr)
  begin
    if (stop_clr)
      stop_seen <= 1'b0;
    else if (scl_clk)
      stop_seen <= 1'b1;
  end

  // ****************************************************************
  // Address select pins, synchronised to the bus clock
  // ****************************************************************

  logic [1:0] addr_meta;
  logic [1:0] addr_sync;

  // Straps are static; two stages still guard against glitches
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_meta <= 2'h0;
      addr_sync <= 2'h0;
    end
    else
    begin
      addr_meta <= addr_sel;
      addr_sync <= addr_meta;
    end
  end

  // ****************************************************************
  // Serial engine, sampled on the rising bus clock
  // ****************************************************************

  sqp_link_state_t state;
  sqp_link_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic [7:0] regs [0:3];
  logic [7:0] next_regs [0:3];
  logic wr_toggle;
  logic next_wr_toggle;
  logic next_start_taken;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [7:0] rx_byte;

  assign rx_byte = {shift[6:0], sda_in};
  assign wr_idx = reg_index(ptr);
  assign rd_idx = reg_index(ptr);

  // A start always wins; all else waits for the next start
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_rw = rw;
    next_tx_byte = tx_byte;
    next_regs = regs;
    next_wr_toggle = wr_toggle;
    next_start_taken = start_seen;
    if (start_seen)
    begin
      next_state = LS_DEVADDR;
      next_shift = {7'h00, sda_in};
      next_cnt = 3'h1;
    end
    else if (stop_seen)
    begin
      next_state = LS_IDLE;
    end
    else
    begin
      case (state)
        LS_DEVADDR:
        begin
          next_shift = rx_byte;
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7)
          begin
            next_rw = sda_in;
            if (shift[6:0] == {SQP_ADDR_FIXED, addr_sync})
              next_state = LS_DEVACK;
            else
              next_state = LS_IDLE;
          end
        end
        LS_DEVACK:
        begin
          next_cnt = 3'h0;
          if (rw)
          begin
            next_state = LS_RDATA;
            next_tx_byte = rd_idx[2] ? regs[rd_idx[1:0]] : SQP_UNMAPPED_RD;
          end
          else
          begin
            next_state = LS_REGADDR;
          end
        end
        LS_REGADDR:
        begin
          next_shift = rx_byte;
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7)
          begin
            next_ptr = rx_byte;
            next_state = LS_REGACK;
          end
        end
        LS_REGACK:
        begin
          next_cnt = 3'h0;
          next_state = LS_WDATA;
        end
        LS_WDATA:
        begin
          next_shift = rx_byte;
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7)
          begin
            if (wr_idx[2])
            begin
              next_regs[wr_idx[1:0]] = rx_byte;
              next_wr_toggle = ~wr_toggle;
            end
            next_state = LS_WACK;
          end
        end
        LS_WACK:
        begin
          next_state = LS_IDLE;
        end
        LS_RDATA:
        begin
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7)
            next_state = LS_RACK;
        end
        LS_RACK:
        begin
          next_state = LS_IDLE;
        end
        default:
        begin
          next_state = LS_IDLE;
        end
      endcase
    end
  end

  // Engine state and register file
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= LS_IDLE;
      cnt <= 3'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      tx_byte <= 8'h00;
      regs[0] <= SQP_QUIET_RST;
      regs[1] <= SQP_CFG_RST;
      regs[2] <= SQP_QUIET_RST;
      regs[3] <= SQP_CFG_RST;
      wr_toggle <= 1'b0;
      start_taken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      rw <= next_rw;
      tx_byte <= next_tx_byte;
      regs <= next_regs;
      wr_toggle <= next_wr_toggle;
      start_taken <= next_start_taken;
    end
  end

  // ****************************************************************
  // Data line driver, updated on the falling bus clock
  // ****************************************************************

  logic next_sda_oe;
  logic [2:0] bit_sel;

  assign bit_sel = 3'h7 - cnt;

  // Open drain: drive only lows, only in ack and read slots
  always_comb
  begin
    case (state)
      LS_DEVACK, LS_REGACK, LS_WACK:
        next_sda_oe = 1'b1;
      LS_RDATA:
        next_sda_oe = ~tx_byte[bit_sel];
      default:
        next_sda_oe = 1'b0;
    endcase
  end

  // Changing on the falling edge keeps SDA still while SCL is high
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Crossing of the control word into the system domain
  // ****************************************************************

  logic [31:0] ctrl_word;

  // A write may follow another no sooner than 27 bus clocks
  sqp_hs_sync #(
    .W(32),
    .RST_VAL({SQP_CFG_RST, SQP_QUIET_RST, SQP_CFG_RST, SQP_QUIET_RST})
  ) u_sync (
    .clk(clk_sys),
    .rst(rst),
    .src_toggle(wr_toggle),
    .src_data({regs[3], regs[2], regs[1], regs[0]}),
    .dst_data(ctrl_word)
  );

  // ****************************************************************
  // Transmitter control, one per output port
  // ****************************************************************

  genvar gp;
  generate
    for (gp = 0; gp < SQP_NPORT; gp++)
    begin : g_port
      // Quiet control in low byte, config in high byte of each half
      sqp_tx_ctrl #(
        .CNT_W(8)
      ) u_tx (
        .clk(clk_sys),
        .rst(rst),
        .quiet_ctrl(ctrl_word[16*gp +: 8]),
        .cfg_ctrl(ctrl_word[16*gp+8 +: 8]),
        .power_on(tx_power_on[gp]),
        .drive_on(tx_drive_on[gp]),
        .term_pull(output_termination_supply_pull[gp])
      );
    end
  endgenerate

endmodule : sqp_config_port

// *** hw/sqp_pkg.sv ***
// ****************************************************************
// Shared constants for the serial configuration port
// ****************************************************************
package sqp_pkg;

  // Fixed upper part of the 7-bit slave address
  localparam logic [4:0] SQP_ADDR_FIXED = 5'h12;

  // Register offsets; the config offsets are free choices
  localparam logic [7:0] SQP_OFS_QUIET_A = 8'hC3;
  localparam logic [7:0] SQP_OFS_QUIET_B = 8'hE3;
  localparam logic [7:0] SQP_OFS_CFG_A = 8'hC0;
  localparam logic [7:0] SQP_OFS_CFG_B = 8'hE0;

  // Values after reset
  localparam logic [7:0] SQP_QUIET_RST = 8'hFF;
  localparam logic [7:0] SQP_CFG_RST = 8'h10;
  localparam logic [7:0] SQP_UNMAPPED_RD = 8'h00;

  // Field positions
  localparam int SQP_EN_BIT = 4;
  localparam int SQP_SQ_HI = 7;
  localparam int SQP_SQ_LO = 4;
  localparam int SQP_DIS_HI = 3;
  localparam int SQP_DIS_LO = 0;
  localparam logic [3:0] SQP_NIB_ZERO = 4'h0;

  // Number of output ports
  localparam int SQP_NPORT = 2;

  // Timing: system clock period, recovery times, cycle counts
  localparam int SQP_CLK_NS = 100;
  localparam int SQP_WAKE_NS = 1000;
  localparam int SQP_RESUME_NS = 100;
  localparam int SQP_WAKE_CYC = (SQP_WAKE_NS + SQP_CLK_NS - 1) / SQP_CLK_NS;
  localparam int SQP_RESUME_CYC =
    (SQP_RESUME_NS + SQP_CLK_NS - 1) / SQP_CLK_NS;

  // Serial engine states
  typedef enum logic [3:0] {
    LS_IDLE = 4'h0,
    LS_DEVADDR = 4'h1,
    LS_DEVACK = 4'h2,
    LS_REGADDR = 4'h3,
    LS_REGACK = 4'h4,
    LS_WDATA = 4'h5,
    LS_WACK = 4'h6,
    LS_RDATA = 4'h7,
    LS_RACK = 4'h8
  } sqp_link_state_t;

  // Transmitter power states
  typedef enum logic [2:0] {
    TX_OFF = 3'h0,
    TX_WAKE = 3'h1,
    TX_QUIET = 3'h2,
    TX_RESUME = 3'h3,
    TX_ON = 3'h4
  } sqp_tx_state_t;

endpackage : sqp_pkg

// *** hw/sqp_hs_sync.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Toggle handshake carrying a word into the system clock domain
// ****************************************************************
module sqp_hs_sync #(
  parameter int W = 32,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic src_toggle,
  input wire logic [W-1:0] src_data,
  output logic [W-1:0] dst_data
);
  import sqp_pkg::*;

  logic [2:0] tog;
  logic [2:0] next_tog;
  logic [W-1:0] next_dst_data;

  // Word is stable long before its toggle is seen here
  always_comb
  begin
    next_tog = {tog[1:0], src_toggle};
    next_dst_data = dst_data;
    if (tog[2] != tog[1])
    begin
      next_dst_data = src_data;
    end
  end

  // tog[0] is read only by tog[1]
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tog <= 3'h0;
      dst_data <= RST_VAL;
    end
    else
    begin
      tog <= next_tog;
      dst_data <= next_dst_data;
    end
  end

endmodule : sqp_hs_sync

// *** hw/sqp_tx_ctrl.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Power state of one transmitter port
// ****************************************************************
module sqp_tx_ctrl #(
  parameter int CNT_W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] quiet_ctrl,
  input wire logic [7:0] cfg_ctrl,
  output logic power_on,
  output logic drive_on,
  output logic term_pull
);
  import sqp_pkg::*;

  sqp_tx_state_t state;
  sqp_tx_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic disable_req;
  logic squelch_req;

  // Only an all-zero nibble counts; partial zeros do nothing
  assign disable_req =
    (quiet_ctrl[SQP_DIS_HI:SQP_DIS_LO] == SQP_NIB_ZERO) |
    ~cfg_ctrl[SQP_EN_BIT];
  assign squelch_req =
    (quiet_ctrl[SQP_SQ_HI:SQP_SQ_LO] == SQP_NIB_ZERO);

  // Disable beats squelch; wake is slow, resume is short
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    if (disable_req)
    begin
      next_state = TX_OFF;
    end
    else
    begin
      case (state)
        TX_OFF:
        begin
          next_state = TX_WAKE;
          next_cnt = CNT_W'(SQP_WAKE_CYC - 1);
        end
        TX_WAKE:
        begin
          if (cnt == '0)
            next_state = squelch_req ? TX_QUIET : TX_ON;
          else
            next_cnt = cnt - 1'b1;
        end
        TX_QUIET:
        begin
          if (!squelch_req)
          begin
            next_state = TX_RESUME;
            next_cnt = CNT_W'(SQP_RESUME_CYC - 1);
          end
        end
        TX_RESUME:
        begin
          if (squelch_req)
            next_state = TX_QUIET;
          else if (cnt == '0)
            next_state = TX_ON;
          else
            next_cnt = cnt - 1'b1;
        end
        TX_ON:
        begin
          if (squelch_req)
            next_state = TX_QUIET;
        end
        default:
        begin
          next_state = TX_OFF;
        end
      endcase
    end
  end

  // Outputs registered from the next state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= TX_ON;
      cnt <= '0;
      power_on <= 1'b1;
      drive_on <= 1'b1;
      term_pull <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      power_on <= (next_state != TX_OFF);
      drive_on <= (next_state == TX_ON);
      term_pull <= (next_state != TX_ON);
    end
  end

endmodule : sqp_tx_ctrl

// *** test/sqp_checker.sv ***
`timescale 1ns/1ps
// ******
// Port checker
// ******
module sqp_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_sel,
  input wire logic [sqp_pkg::SQP_NPORT-1:0] tx_power_on,
  input wire logic [sqp_pkg::SQP_NPORT-1:0] tx_drive_on,
  input wire logic [sqp_pkg::SQP_NPORT-1:0] output_termination_supply_pull
);
  import sqp_pkg::*;
  logic oe_hi;
  logic next_oe_hi;
  // Enable as held over the SCL high phase
  always_comb next_oe_hi = sda_oe;
  always_ff @(posedge scl_clk or posedge rst)
    if (rst)
      oe_hi <= 1'b0;
    else
      oe_hi <= next_oe_hi;
  pull_follow_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    output_termination_supply_pull == ~tx_drive_on)
    else $error("pull differs from drive");
  drive_power_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (tx_drive_on & ~tx_power_on) == '0)
    else $error("current on while powered down");
  wake_port_a_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(tx_power_on[0]) |-> (!tx_drive_on[0]) [*8])
    else $error("port A woke too fast");
  wake_port_b_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(tx_power_on[1]) |-> (!tx_drive_on[1]) [*8])
    else $error("port B woke too fast");
  off_port_a_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(tx_power_on[0]) |-> !tx_drive_on[0])
    else $error("power down left current on");
  sda_open_a: assert property (
    @(posedge scl_clk) disable iff (rst) !sda_out)
    else $error("data driven high");
  oe_low_phase_a: assert property (
    @(negedge scl_clk) disable iff (rst) sda_oe == oe_hi)
    else $error("data moved while clock high");
  oe_span_a: assert property (
    @(posedge scl_clk) disable iff (rst)
    sda_oe [*8] ##1 sda_oe |=> !sda_oe)
    else $error("data held past read byte");
endmodule : sqp_checker

// *** test/sqp_master.sv ***
`timescale 1ns/1ps
// ******
// Bus master model; clock parked high after a stop, left low before a repeated start
// ******
module sqp_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  import sqp_pkg::*;
  localparam int Q = 16;
  // Idle bus, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data high before clock rises
  task automatic bus_start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : bus_start
  task automatic bus_stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask : bus_stop
  // One clock pulse, data sampled mid-high
  task automatic pulse(output logic seen);
    #Q scl = 1'b1;
    #Q seen = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : pulse
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      pulse(seen);
    end
    sda_low = 1'b0;
    pulse(seen);
    ack = (seen === 1'b0);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(seen);
      b[i] = seen;
    end
    sda_low = 1'b1;
    pulse(seen);
  endtask : recv_byte
  // Keep set: no stop, next frame opens with a repeated start
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
    input logic [7:0] d, input logic keep, output logic ok);
    logic a0, a1, a2;
    bus_start();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    if (!keep)
      bus_stop();
    ok = a0 & a1 & a2;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
    input logic set_ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    a0 = 1'b1;
    a1 = 1'b1;
    bus_start();
    if (set_ptr)
    begin
      send_byte({dev, 1'b0}, a0);
      send_byte(ofs, a1);
      bus_start();
    end
    send_byte({dev, 1'b1}, a2);
    recv_byte(d);
    bus_stop();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : sqp_master

// *** test/sqp_config_port_tb.sv ***
`timescale 1ns/1ps
// ******
// Bench for the serial configuration port
// ******
module sqp_config_port_tb;
  import sqp_pkg::*;
  typedef struct packed {
    logic [7:0] ofs;
    logic [7:0] dat;
    logic [1:0] pw;
    logic [1:0] dr;
  } sqp_row_t;
  // Write, then expected power and current; bit 0 is port A
  localparam sqp_row_t ROWS [12] = '{
    '{8'hC3, 8'h0F, 2'h3, 2'h2}, '{8'hC3, 8'hF0, 2'h2, 2'h2},
    '{8'hC3, 8'hFF, 2'h3, 2'h3}, '{8'hC3, 8'h07, 2'h3, 2'h2},
    '{8'hC3, 8'hF7, 2'h3, 2'h3}, '{8'hE3, 8'h0F, 2'h3, 2'h1},
    '{8'hE3, 8'h00, 2'h1, 2'h1}, '{8'hE3, 8'hFF, 2'h3, 2'h3},
    '{8'hC0, 8'h00, 2'h2, 2'h2}, '{8'hC0, 8'h10, 2'h3, 2'h3},
    '{8'hE0, 8'hEF, 2'h1, 2'h1}, '{8'hE0, 8'h10, 2'h3, 2'h3}};
  logic clk_sys, rst, scl_clk, sda_low, sda_in, sda_out, sda_oe, ok;
  logic [1:0] addr_sel, tx_power_on, tx_drive_on, pull;
  logic [6:0] dev;
  logic [7:0] rd;
  int bad_count, checked;
  // Open drain with pull-up; delay keeps data off clock edges
  assign #1 sda_in = ~((sda_oe & ~sda_out) | sda_low);
  sqp_config_port uut (.clk_sys, .rst, .scl_clk, .sda_in, .sda_out,
    .sda_oe, .addr_sel, .tx_power_on, .tx_drive_on,
    .output_termination_supply_pull(pull));
  sqp_master mst (.scl(scl_clk), .sda_low, .sda(sda_in));
  always #50 clk_sys = ~clk_sys;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: 0x%0h vs 0x%0h", $time, seen, exp);
    end
  endtask : check
  // Wait past crossing and wake-up, then look at the outputs
  task automatic port_expect(input logic [1:0] pw, input logic [1:0] dr);
    repeat (20) @(posedge clk_sys);
    #5;
    check({6'h0, tx_power_on}, {6'h0, pw});
    check({6'h0, tx_drive_on}, {6'h0, dr});
    check({6'h0, pull}, {6'h0, ~dr});
  endtask : port_expect
  task automatic complete_run();
    $display("%0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Whole run needs about 0.1 ms
  initial
  begin
    #1000000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    addr_sel = 2'h3;
    dev = {SQP_ADDR_FIXED, 2'h3};
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    #5 rst = 1'b0;
    foreach (ROWS[i])
    begin
      mst.write_reg(dev, ROWS[i].ofs, ROWS[i].dat, 1'b1, ok);
      check({7'h0, ok}, 8'h01);
      mst.read_reg(dev, 8'h00, 1'b0, rd, ok);
      check(rd, ROWS[i].dat);
      port_expect(ROWS[i].pw, ROWS[i].dr);
      $display("Row %0d done", i);
    end
    // Pointer kept across a stop, same byte read twice
    mst.write_reg(dev, SQP_OFS_QUIET_B, 8'hFE, 1'b0, ok);
    repeat (2)
    begin
      mst.read_reg(dev, 8'h00, 1'b0, rd, ok);
      check(rd, 8'hFE);
    end
    // Unmapped offset is acked, ignored, reads zero
    mst.write_reg(dev, 8'h55, 8'hA5, 1'b0, ok);
    check({7'h0, ok}, 8'h01);
    mst.read_reg(dev, 8'h55, 1'b1, rd, ok);
    check(rd, SQP_UNMAPPED_RD);
    $display("Pointer test done");
    // New strap value: old address refused, new one answered
    @(posedge clk_sys);
    #5 addr_sel = 2'h1;
    mst.write_reg(dev, SQP_OFS_QUIET_A, 8'h0F, 1'b0, ok);
    check({7'h0, ok}, 8'h00);
    dev = {SQP_ADDR_FIXED, 2'h1};
    mst.read_reg(dev, SQP_OFS_QUIET_A, 1'b1, rd, ok);
    check(rd, 8'hF7);
    port_expect(2'h3, 2'h3);
    $display("Address test done");
    // Wake from disable: power returns first, current about 1 us later
    mst.write_reg(dev, SQP_OFS_QUIET_A, 8'hF0, 1'b0, ok);
    port_expect(2'h2, 2'h2);
    mst.write_reg(dev, SQP_OFS_QUIET_A, 8'hFF, 1'b0, ok);
    repeat (5) @(posedge clk_sys);
    #5;
    check({6'h0, tx_power_on}, 8'h03);
    check({6'h0, tx_drive_on}, 8'h02);
    port_expect(2'h3, 2'h3);
    $display("Wake test done");
    // Disable port A, then reset in mid-run
    mst.write_reg(dev, SQP_OFS_QUIET_A, 8'h00, 1'b0, ok);
    port_expect(2'h2, 2'h2);
    @(posedge clk_sys);
    #5 rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #5 rst = 1'b0;
    mst.read_reg(dev, 8'h00, 1'b0, rd, ok);
    check(rd, SQP_UNMAPPED_RD);
    mst.read_reg(dev, SQP_OFS_QUIET_A, 1'b1, rd, ok);
    check(rd, SQP_QUIET_RST);
    mst.read_reg(dev, SQP_OFS_QUIET_B, 1'b1, rd, ok);
    check(rd, SQP_QUIET_RST);
    port_expect(2'h3, 2'h3);
    $display("Reset test done");
    complete_run();
  end
endmodule : sqp_config_port_tb
bind sqp_config_port sqp_checker chk (.clk_sys, .rst, .scl_clk, .sda_in,
  .sda_out, .sda_oe, .addr_sel, .tx_power_on, .tx_drive_on,
  .output_termination_supply_pull);
